// file: rtl/ispp_pkg.sv
// package of constants for the serial programming host controller
// assumes a 100 MHz system clock; all times below are converted to cycles
// Functional notes
// - at power-up entry the host holds reset low with supply on and waits at least 10 us before raising select.
// - after raising select at power-up entry the host waits the startup timeout before any session.
// - power-down: clock low, lag time, select high, data out floated, 25 ns, then select and clock floated.
// - after floating select at power-down the host removes supply within 1 us.
// - running-device entry: reset low, select high, then wait reset-to-float delay plus at least 100 ns.
// - exit: clock low, lag time, select high, data out floated, 25 ns, reset high, clock floated.
// - after raising reset on exit the host floats select within zero to two target clocks.
// - the host is the serial master, target the slave; full duplex, byte oriented.
// - bytes go most significant bit first in mode 0: sample on rising, change on falling edge.
// - serial clock period at least 200 ns, high at least 75 ns, low at least 50 ns.
// - the host waits 2.5 ms per write, 5 ms per auto-erase write, 7.5 ms per chip erase.
`default_nettype none
package ispp_pkg;
    // ----------------------------------------------------------------
    // clock and times
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int PWRUP_NS = 10000;
    localparam int SSZ_NS = 25;
    localparam int PWRDN_NS = 1000;
    localparam int STL_NS = 100;
    localparam int TCLCL_MAX_NS = 60;
    localparam int SCK_HIGH_NS = 100;
    localparam int SCK_LOW_NS = 100;
    localparam int WR_US = 2500;
    localparam int AWR_US = 5000;
    localparam int ERS_US = 7500;
    localparam int SUT_US = 16000;
    // least times in ns round up; longest times and the us waits round down
    localparam int PWRUP_CYC = (PWRUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SSZ_CYC = (SSZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PWRDN_CYC = (PWRDN_NS * 1000) / CLK_PERIOD_PS;
    localparam int RLZ_STL_CYC = ((2 * TCLCL_MAX_NS + STL_NS) * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int RHZ_CYC = 1;
    localparam int SCK_HIGH_CYC = (SCK_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCK_LOW_CYC = (SCK_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_CYC = (WR_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int AWR_CYC = (AWR_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int ERS_CYC = (ERS_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int SUT_CYC = (SUT_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int CNT_W = 24;
    // ----------------------------------------------------------------
    // commands and nonvolatile wait kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ISPP_CMD_PWRUP = 3'h0,
        ISPP_CMD_START = 3'h1,
        ISPP_CMD_XFER = 3'h2,
        ISPP_CMD_WAIT = 3'h3,
        ISPP_CMD_EXIT = 3'h4,
        ISPP_CMD_PWRDN = 3'h5
    } ispp_cmd_e;
    typedef enum logic [1:0] {
        ISPP_NV_WR = 2'h0,
        ISPP_NV_AWR = 2'h1,
        ISPP_NV_ERS = 2'h2
    } ispp_nv_e;
endpackage : ispp_pkg
`default_nettype wire

// file: rtl/ispp_shift.sv
// mode 0 byte shifter for the programming link, master side
// assumes miso_sync is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module ispp_shift
    import ispp_pkg::*;
#(
    parameter int HIGH_CYC = SCK_HIGH_CYC,
    parameter int LOW_CYC = SCK_LOW_CYC
)
(
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic start, // begin one byte
    input wire logic [7:0] tx_byte, // byte to send
    input wire logic miso_sync, // synchronised target data
    output logic sck, // serial clock level
    output logic mosi, // serial data out
    output logic done, // one-cycle end pulse
    output logic [7:0] rx_byte // byte received
);
    initial begin
        if (HIGH_CYC < 1 || LOW_CYC < 1 || HIGH_CYC >= 256 || LOW_CYC >= 256)
            $error("ispp_shift: phase counts out of range");
    end
    logic busy_reg, busy_next, sck_reg, sck_next, done_reg, done_next;
    logic [7:0] tx_reg, tx_next, rx_reg, rx_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] ph_reg, ph_next;
    // bit engine: data set up during low phase, sampled on rising edge
    always_comb
    begin
        busy_next = busy_reg;
        sck_next = sck_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        bit_next = bit_reg;
        ph_next = ph_reg;
        done_next = 1'b0;
        if (!busy_reg) begin
            if (start) begin
                busy_next = 1'b1;
                tx_next = tx_byte; // msb presented first
                bit_next = 3'h7;
                ph_next = 8'(LOW_CYC - 1);
            end
        end else if (ph_reg != 8'h00) begin
            ph_next = ph_reg - 8'h01;
        end else if (!sck_reg) begin
            sck_next = 1'b1; // rising edge: both sides sample
            rx_next = {rx_reg[6:0], miso_sync};
            ph_next = 8'(HIGH_CYC - 1); // high phase at least 75 ns
        end else begin
            sck_next = 1'b0; // falling edge: next bit driven
            tx_next = {tx_reg[6:0], 1'b0};
            ph_next = 8'(LOW_CYC - 1); // low phase at least 50 ns
            if (bit_reg == 3'h0) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                bit_next = bit_reg - 3'h1;
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (rst) begin
            busy_reg <= 1'b0;
            sck_reg <= 1'b0;
            done_reg <= 1'b0;
            tx_reg <= 8'h00;
            rx_reg <= 8'h00;
            bit_reg <= 3'h0;
            ph_reg <= 8'h00;
        end else begin
            busy_reg <= busy_next;
            sck_reg <= sck_next;
            done_reg <= done_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            bit_reg <= bit_next;
            ph_reg <= ph_next;
        end
    end
    assign sck = sck_reg;
    assign mosi = tx_reg[7];
    assign done = done_reg;
    assign rx_byte = rx_reg;
    // period of at least 200 ns means the high phase lasts its full count
    // eight cycles high covers 75 ns, five cycles low covers 50 ns
    a_sck_high_min: assert property (@(posedge clk) disable iff (rst)
        $rose(sck_reg) |=> sck_reg [*7])
        else $error("serial clock high too short");
    a_sck_low_min: assert property (@(posedge clk) disable iff (rst)
        $fell(sck_reg) |=> !sck_reg [*4])
        else $error("serial clock low too short");
    a_mosi_stable_high: assert property (@(posedge clk) disable iff (rst)
        sck_reg && $past(sck_reg) |-> $stable(tx_reg[7]))
        else $error("data moved in high");
endmodule : ispp_shift
`default_nettype wire

// file: rtl/ispp_host.sv
// host controller for serial in-system programming of a target
// assumes target pins are joined outside with enables; supply switch is power_on
`timescale 1ns/1ps
`default_nettype none
module ispp_host
    import ispp_pkg::*;
#(
    parameter int PWRUP_WAIT = PWRUP_CYC,
    parameter int SUT_WAIT = SUT_CYC,
    parameter int WR_WAIT = WR_CYC,
    parameter int AWR_WAIT = AWR_CYC,
    parameter int ERS_WAIT = ERS_CYC
)
(
    input wire logic clk, // system clock, 100 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic cmd_valid, // command strobe
    input wire logic [2:0] cmd_op, // command code
    input wire logic [7:0] cmd_data, // byte to send
    input wire logic [1:0] cmd_nv, // nonvolatile wait kind
    output logic cmd_ready, // idle, command accepted
    output logic rsp_valid, // one-cycle completion pulse
    output logic [7:0] rsp_data, // received byte
    output logic session_active, // session open
    output logic power_on, // target supply switch
    output logic rst_n_o, // target reset level
    output logic rst_n_oe, // target reset drive enable
    output logic ss_n_o, // target select level
    output logic ss_n_oe, // target select drive enable
    output logic sck_o, // serial clock level
    output logic sck_oe, // serial clock drive enable
    output logic mosi_o, // serial data level
    output logic mosi_oe, // serial data drive enable
    input wire logic miso_i // target serial data
);
    localparam int MAXW = (1 << CNT_W) - 1;
    initial begin
        if (PWRUP_WAIT < 1 || SUT_WAIT < 1 || ERS_WAIT > MAXW || SUT_WAIT > MAXW
            || WR_WAIT < 1 || AWR_WAIT < 1)
            $error("ispp_host: wait parameter out of range");
    end
    // ----------------------------------------------------------------
    // pin input synchroniser
    // ----------------------------------------------------------------
    logic miso_m_reg, miso_s_reg;
    always_ff @(posedge clk)
    begin
        miso_m_reg <= miso_i;
        miso_s_reg <= miso_m_reg;
    end
    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ISPP_OFF = 4'h0, ISPP_PWRUP = 4'h1, ISPP_SUT = 4'h2, ISPP_IDLE = 4'h3,
        ISPP_STL = 4'h4, ISPP_XFER = 4'h5, ISPP_NVW = 4'h6, ISPP_LAG = 4'h7,
        ISPP_SSZ = 4'h8, ISPP_RHZ = 4'h9, ISPP_PDN = 4'hA, ISPP_RUN = 4'hB
    } ispp_state_e;
    ispp_state_e st_reg, st_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic pwr_reg, pwr_next, rstn_reg, rstn_next, rstoe_reg, rstoe_next;
    logic ss_reg, ss_next, ssoe_reg, ssoe_next, sckoe_reg, sckoe_next, mosioe_reg, mosioe_next;
    logic exit_reg, exit_next, rdy_reg, rdy_next, rsp_reg, rsp_next, act_reg, act_next;
    logic sh_start, sh_sck, sh_mosi, sh_done;
    logic [7:0] sh_rx;
    logic sck_reg, mosi_reg;
    logic [7:0] rspd_reg;
    logic cmd_take;
    assign cmd_take = cmd_valid && rdy_reg;
    assign sh_start = cmd_take && ispp_cmd_e'(cmd_op) == ISPP_CMD_XFER && st_reg == ISPP_IDLE;
    ispp_shift u_shift (
        .clk(clk),
        .rst(rst),
        .start(sh_start),
        .tx_byte(cmd_data),
        .miso_sync(miso_s_reg),
        .sck(sh_sck),
        .mosi(sh_mosi),
        .done(sh_done),
        .rx_byte(sh_rx)
    );
    // next state of the entry, session and exit sequences
    always_comb
    begin
        st_next = st_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        pwr_next = pwr_reg;
        rstn_next = rstn_reg;
        rstoe_next = rstoe_reg;
        ss_next = ss_reg;
        ssoe_next = ssoe_reg;
        sckoe_next = sckoe_reg;
        mosioe_next = mosioe_reg;
        exit_next = exit_reg;
        act_next = act_reg;
        rsp_next = 1'b0;
        rdy_next = 1'b0;
        case (st_reg)
            ISPP_OFF, ISPP_RUN:
            begin
                rdy_next = 1'b1;
                if (cmd_take && ispp_cmd_e'(cmd_op) == ISPP_CMD_PWRUP && st_reg == ISPP_OFF) begin
                    // only route into a target with reset as I/O or fuse off
                    pwr_next = 1'b1;
                    rstn_next = 1'b0; // reset held low while supply rises
                    rstoe_next = 1'b1;
                    ss_next = 1'b0;
                    ssoe_next = 1'b1;
                    sckoe_next = 1'b1;
                    cnt_next = CNT_W'(PWRUP_WAIT);
                    st_next = ISPP_PWRUP;
                    rdy_next = 1'b0;
                end else if (cmd_take && ispp_cmd_e'(cmd_op) == ISPP_CMD_START
                    && st_reg == ISPP_RUN) begin
                    rstn_next = 1'b0; // reset low and select high in the same cycle
                    rstoe_next = 1'b1;
                    ss_next = 1'b1;
                    ssoe_next = 1'b1;
                    sckoe_next = 1'b1;
                    cnt_next = CNT_W'(RLZ_STL_CYC); // target floats within two of its clocks
                    st_next = ISPP_STL;
                    rdy_next = 1'b0;
                end else if (cmd_take) begin
                    rsp_next = 1'b1; // illegal here: answered at once, nothing done
                end
            end
            ISPP_PWRUP:
                if (cnt_reg == '0) begin
                    ss_next = 1'b1; // select high after 10 us
                    cnt_next = CNT_W'(SUT_WAIT);
                    st_next = ISPP_SUT;
                end
            ISPP_SUT, ISPP_STL:
                if (cnt_reg == '0) begin // startup timeout or settling over
                    mosioe_next = 1'b1;
                    act_next = 1'b1;
                    rsp_next = 1'b1;
                    rdy_next = 1'b1;
                    st_next = ISPP_IDLE;
                end
            ISPP_IDLE:
            begin
                rdy_next = 1'b1;
                if (cmd_take) begin
                    rdy_next = 1'b0;
                    case (ispp_cmd_e'(cmd_op))
                        ISPP_CMD_XFER: begin
                            ss_next = 1'b0; // lead: sck held low a full low phase first
                            st_next = ISPP_XFER;
                        end
                        ISPP_CMD_WAIT: begin
                            case (ispp_nv_e'(cmd_nv)) // nonvolatile write waits
                                ISPP_NV_WR: cnt_next = CNT_W'(WR_WAIT);
                                ISPP_NV_AWR: cnt_next = CNT_W'(AWR_WAIT);
                                default: cnt_next = CNT_W'(ERS_WAIT);
                            endcase
                            st_next = ISPP_NVW;
                        end
                        ISPP_CMD_EXIT, ISPP_CMD_PWRDN: begin
                            exit_next = ispp_cmd_e'(cmd_op) == ISPP_CMD_EXIT;
                            cnt_next = CNT_W'(SCK_LOW_CYC); // sck is low; lag time
                            st_next = ISPP_LAG;
                        end
                        default: begin
                            rsp_next = 1'b1;
                            rdy_next = 1'b1;
                        end
                    endcase
                end
            end
            ISPP_XFER:
                if (sh_done) begin
                    rsp_next = 1'b1;
                    rdy_next = 1'b1;
                    st_next = ISPP_IDLE; // select stays low across bytes, raised at exit
                end
            ISPP_NVW:
                if (cnt_reg == '0) begin
                    rsp_next = 1'b1;
                    rdy_next = 1'b1;
                    st_next = ISPP_IDLE;
                end
            ISPP_LAG:
                if (cnt_reg == '0) begin
                    ss_next = 1'b1; // select high after lag
                    mosioe_next = 1'b0; // data out floated
                    cnt_next = CNT_W'(SSZ_CYC);
                    st_next = ISPP_SSZ;
                end
            ISPP_SSZ:
                if (cnt_reg == '0) begin
                    sckoe_next = 1'b0;
                    act_next = 1'b0;
                    if (exit_reg) begin
                        rstn_next = 1'b1; // reset high ends session
                        cnt_next = CNT_W'(RHZ_CYC);
                        st_next = ISPP_RHZ;
                    end else begin
                        ssoe_next = 1'b0; // select and clock floated together
                        cnt_next = CNT_W'(PWRDN_CYC);
                        st_next = ISPP_PDN;
                    end
                end
            ISPP_RHZ:
                if (cnt_reg == '0) begin
                    ssoe_next = 1'b0; // select floated within two target clocks
                    rstoe_next = 1'b0;
                    rsp_next = 1'b1;
                    rdy_next = 1'b1;
                    st_next = ISPP_RUN;
                end
            ISPP_PDN:
            begin
                pwr_next = 1'b0; // supply off well inside 1 us
                rstoe_next = 1'b0;
                rstn_next = 1'b1;
                rsp_next = 1'b1;
                rdy_next = 1'b1;
                st_next = ISPP_OFF;
            end
            default: st_next = ISPP_OFF;
        endcase
    end
    // state registers, outputs straight from flops
    always_ff @(posedge clk)
    begin
        if (rst) begin
            st_reg <= ISPP_OFF;
            cnt_reg <= '0;
            pwr_reg <= 1'b0;
            rstn_reg <= 1'b1;
            rstoe_reg <= 1'b0;
            ss_reg <= 1'b1;
            ssoe_reg <= 1'b0;
            sckoe_reg <= 1'b0;
            mosioe_reg <= 1'b0;
            exit_reg <= 1'b0;
            act_reg <= 1'b0;
            rsp_reg <= 1'b0;
            rdy_reg <= 1'b0;
            sck_reg <= 1'b0;
            mosi_reg <= 1'b0;
            rspd_reg <= 8'h00;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            pwr_reg <= pwr_next;
            rstn_reg <= rstn_next;
            rstoe_reg <= rstoe_next;
            ss_reg <= ss_next;
            ssoe_reg <= ssoe_next;
            sckoe_reg <= sckoe_next;
            mosioe_reg <= mosioe_next;
            exit_reg <= exit_next;
            act_reg <= act_next;
            rsp_reg <= rsp_next;
            rdy_reg <= rdy_next;
            sck_reg <= sh_sck; // one flop after the shifter; mosi delayed alike
            mosi_reg <= sh_mosi;
            rspd_reg <= sh_done ? sh_rx : rspd_reg;
        end
    end
    assign cmd_ready = rdy_reg;
    assign rsp_valid = rsp_reg;
    assign rsp_data = rspd_reg;
    assign session_active = act_reg;
    assign power_on = pwr_reg;
    assign rst_n_o = rstn_reg;
    assign rst_n_oe = rstoe_reg;
    assign ss_n_o = ss_reg;
    assign ss_n_oe = ssoe_reg;
    assign sck_o = sck_reg;
    assign sck_oe = sckoe_reg;
    assign mosi_o = mosi_reg;
    assign mosi_oe = mosioe_reg;
    a_pwrup_reset_low: assert property (@(posedge clk) disable iff (rst)
        $rose(ss_reg) && st_reg == ISPP_SUT |-> !rstn_reg && pwr_reg)
        else $error("reset not low");
    a_session_after_sut: assert property (@(posedge clk) disable iff (rst)
        $rose(act_reg) |-> $past(st_reg) inside {ISPP_SUT, ISPP_STL})
        else $error("early session");
    a_pdn_power_off: assert property (@(posedge clk) disable iff (rst)
        $fell(ssoe_reg) && !exit_reg |-> ##[1:2] !pwr_reg)
        else $error("supply left on");
    a_exit_select_float: assert property (@(posedge clk) disable iff (rst)
        $rose(rstn_reg) && exit_reg |-> ##[1:3] !ssoe_reg)
        else $error("select float late");
    a_sck_low_at_select: assert property (@(posedge clk) disable iff (rst)
        $changed(ss_reg) |-> !sck_reg)
        else $error("select moved with clock high");
    // select is already high at a running-device start, so key on the reset fall
    a_stl_wait_len: assert property (@(posedge clk) disable iff (rst)
        $fell(rstn_reg) && st_reg == ISPP_STL |-> !act_reg [*8] ##1 !act_reg [*8] ##1 !act_reg [*6])
        else $error("settle too short");
endmodule : ispp_host
`default_nettype wire

// file: bench/ispp_target_model.sv
// behavioural target: slave side of the serial programming port
// assumes pin levels are already resolved from the host's enables
`timescale 1ns/1ps
`default_nettype none
module ispp_target_model (
    input wire logic power, // supply present
    input wire logic rst_n, // reset pin level
    input wire logic ss_n, // select pin level
    input wire logic sck, // serial clock level
    input wire logic mosi, // serial data in
    input wire logic [7:0] reply, // byte to answer with
    output logic miso, // serial data out
    output logic [7:0] got // last byte received
);
    // ----------------------------------------------------------------
    // session state and shifters
    // ----------------------------------------------------------------
    logic ses = 1'b0;
    logic [7:0] sh_in = 8'h00;
    logic [7:0] sh_out = 8'h00;
    logic [2:0] cnt = 3'h0;
    initial miso = 1'b0;
    initial got = 8'h00;
    // entry only while reset is held low; raising reset ends it, fuses apply
    // reset fall enters from a running state, own I/O released
    always @(posedge ss_n or posedge rst_n or negedge rst_n)
    begin
        ses = power && !rst_n;
        cnt = 3'h0;
        miso = ~miso; // released line must not show a stale bit
    end
    // new byte at select fall or at the fall after the eighth rise
    always @(negedge ss_n or negedge sck)
    begin
        if (!ss_n && ses && cnt == 3'h0)
            sh_out = reply;
        if (!ss_n && ses)
        begin
            miso = sh_out[7]; // change on falling edge, msb first
            sh_out = {sh_out[6:0], 1'b0};
        end
    end
    // a reply set between bytes replaces the one preloaded at the eighth fall
    always @(reply)
    begin
        if (!ss_n && ses && cnt == 3'h0)
        begin
            sh_out = reply;
            miso = sh_out[7];
            sh_out = {sh_out[6:0], 1'b0};
        end
    end
    // sample on the rising edge, msb first
    always @(posedge sck)
    begin
        if (!ss_n && ses)
        begin
            sh_in = {sh_in[6:0], mosi};
            cnt = cnt + 3'h1;
            if (cnt == 3'h0)
                got = sh_in;
        end
    end
endmodule : ispp_target_model
`default_nettype wire

// file: bench/isp_serial_programming_entry_exit_test.sv
// self-checking bench for the serial programming host controller
// assumes pull-ups on target reset and select; long waits shortened
`timescale 1ns/1ps
`default_nettype none
module isp_serial_programming_entry_exit_test;
    import ispp_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, pins and monitor
    // ----------------------------------------------------------------
    localparam int PW = 30;
    localparam int SW = 40;
    localparam int NV_W [4] = '{20, 30, 40, 40};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [7:0] cmd_data = 8'h00;
    logic [1:0] cmd_nv = 2'h0;
    logic miso_i = 1'b0;
    logic [7:0] reply = 8'h00;
    logic cmd_ready, rsp_valid, session_active, power_on, rst_n_o, rst_n_oe;
    logic ss_n_o, ss_n_oe, sck_o, sck_oe, mosi_o, mosi_oe, miso_w;
    logic [7:0] rsp_data;
    logic [7:0] got;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int ph = 0;
    int hi = 0;
    int t_pw, t_pwoff, t_ssr, t_ssz, t_rr, t_rf, t_ses, t_sckf;
    int lat;
    ispp_host #(.PWRUP_WAIT(PW), .SUT_WAIT(SW), .WR_WAIT(NV_W[0]), .AWR_WAIT(NV_W[1]),
        .ERS_WAIT(NV_W[2])) i_ispp_host (.clk, .rst, .cmd_valid, .cmd_op, .cmd_data,
        .cmd_nv, .cmd_ready, .rsp_valid, .rsp_data, .session_active, .power_on, .rst_n_o,
        .rst_n_oe, .ss_n_o, .ss_n_oe, .sck_o, .sck_oe, .mosi_o, .mosi_oe, .miso_i);
    ispp_target_model i_ispp_target_model (.power(power_on),
        .rst_n(rst_n_oe ? rst_n_o : 1'b1), .ss_n(ss_n_oe ? ss_n_o : 1'b1),
        .sck(sck_oe & sck_o), .mosi(mosi_oe ? mosi_o : ~mosi_o), .reply, .miso(miso_w),
        .got);
    initial forever #5 clk = ~clk;
    always @(posedge clk) miso_i <= miso_w;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // event stamps and serial clock phase lengths; phase checks need sck_oe, the data check mosi_oe
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ph <= $changed(sck_o) ? 1 : ph + 1;
        if ($rose(power_on)) t_pw <= cyc;
        if ($fell(power_on)) t_pwoff <= cyc;
        if ($rose(ss_n_o)) t_ssr <= cyc;
        if ($fell(ss_n_oe)) t_ssz <= cyc;
        if ($rose(rst_n_o)) t_rr <= cyc;
        if ($fell(rst_n_o)) t_rf <= cyc;
        if ($rose(session_active)) t_ses <= cyc;
        if ($fell(sck_o)) t_sckf <= cyc;
        if ($fell(sck_o)) hi <= ph;
        if (sck_oe && $fell(sck_o)) check(32'(ph >= 8), 1);
        if (sck_oe && $rose(sck_o)) check(32'(ph >= 5 && ph + hi >= 20), 1);
        if (mosi_oe && sck_o && $stable(sck_o) && $changed(mosi_o)) check(0, 1);
    end
    // one command, waits for its completion pulse with a bound
    task automatic do_cmd(input logic [2:0] op, input logic [7:0] d, input logic [1:0] nv);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            n++;
        end
        cmd_op <= op;
        cmd_data <= d;
        cmd_nv <= nv;
        cmd_valid <= 1'b1;
        @(posedge clk);
        cmd_valid <= 1'b0;
        lat = 0;
        do begin @(posedge clk); lat++; end while (rsp_valid !== 1'b1 && lat < 5000);
        check(32'(lat < 5000), 1);
        @(posedge clk); // let the monitor's stamps of the last edge land
    endtask : do_cmd
    task automatic test_refused();
        foreach (NV_W[i])
        begin
            do_cmd(3'(i == 0 ? 1 : i + 1), 8'h00, 2'h0); // start, xfer, wait, exit
            check(32'(lat <= 3), 1);
            check({power_on, session_active, ss_n_oe}, 0);
        end
        $display("test_refused done");
    endtask : test_refused
    task automatic test_pwrup();
        do_cmd(ISPP_CMD_PWRUP, 8'h00, 2'h0);
        check(32'(t_ssr - t_pw >= PW), 1);
        check(32'(t_ses - t_ssr >= SW), 1);
        check({rst_n_o, rst_n_oe, power_on, session_active}, 4'h7);
        $display("test_pwrup done");
    endtask : test_pwrup
    // back-to-back bytes, select held low between them
    task automatic test_xfer(input logic [7:0] tx, input logic [7:0] rx);
        reply <= rx;
        do_cmd(ISPP_CMD_XFER, tx, 2'h0);
        check(rsp_data, rx);
        check(got, tx);
        check(ss_n_o, 0);
        $display("test_xfer done");
    endtask : test_xfer
    task automatic test_wait();
        foreach (NV_W[i])
        begin
            do_cmd(ISPP_CMD_WAIT, 8'h00, 2'(i));
            check(32'(lat >= NV_W[i] && lat <= NV_W[i] + 8), 1);
        end
        $display("test_wait done");
    endtask : test_wait
    task automatic test_exit();
        do_cmd(ISPP_CMD_EXIT, 8'h00, 2'h0);
        check(32'(t_ssr - t_sckf >= 5), 1);
        check(32'(t_rr - t_ssr >= SSZ_CYC), 1);
        check(32'(t_ssz - t_rr <= 12), 1);
        check({session_active, mosi_oe, sck_oe, power_on}, 4'h1);
        $display("test_exit done");
    endtask : test_exit
    task automatic test_start();
        do_cmd(ISPP_CMD_START, 8'h00, 2'h0);
        check(32'(t_ses - t_rf >= RLZ_STL_CYC), 1);
        check({rst_n_o, ss_n_o, session_active}, 3'h3);
        $display("test_start done");
    endtask : test_start
    task automatic test_pwrdn();
        do_cmd(ISPP_CMD_PWRDN, 8'h00, 2'h0);
        repeat (3) @(posedge clk);
        check(32'(t_ssz - t_ssr >= SSZ_CYC), 1);
        check(32'(t_pwoff - t_ssz <= PWRDN_CYC), 1);
        check({power_on, ss_n_oe, sck_oe, mosi_oe}, 0);
        $display("test_pwrdn done");
    endtask : test_pwrdn
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        #200000;
        failures++;
        final_report();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        check({power_on, cmd_ready, rst_n_oe, ss_n_oe, sck_oe, mosi_oe}, 0);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        test_refused();
        test_pwrup();
        test_xfer(8'hA5, 8'h3C);
        test_xfer(8'h5A, 8'hC3);
        test_wait();
        test_exit();
        test_start();
        test_xfer(8'h81, 8'h7E);
        test_pwrdn();
        final_report();
    end
endmodule : isp_serial_programming_entry_exit_test
`default_nettype wire
